// >>> design/sdat_pkg.sv
// Constants for segment and DMA address translation.
// Assumes a single clock domain; all users reference names as sdat_pkg::name.
package sdat_pkg;
   // Effective address split
   localparam int EA_SEL_MSB = 31;
   localparam int EA_SEL_LSB = 28;
   localparam int OFFSET_W = 28;
   localparam int SEG_COUNT = 16;
   localparam int SID_W = 12;
   localparam int VADDR_W = SID_W + OFFSET_W;
   // Segment register fields
   localparam int SEG_VALID_BIT = 15;
   localparam int SEG_CHAN_INH_BIT = 16;
   localparam int SEG_PROC_INH_BIT = 17;
   localparam int SEG_SID_LSB = 18;
   localparam int SEG_SID_MSB = 29;
   localparam logic [31:0] SEG_RESET = 32'h0000_0000;
   // Dedicated segments
   localparam logic [3:0] SEG_IO_OUT = 4'hf;
   localparam logic [3:0] SEG_IO_IN = 4'he;
   // Sixteen-megabyte windows inside the outbound segment
   localparam logic [3:0] WIN_BUS_IO = 4'h0;
   localparam logic [3:0] WIN_BUS_MEM = 4'h4;
   // DMA side
   localparam int CHAN_COUNT = 8;
   localparam int CHAN_W = 3;
   localparam int DMA_ADDR_W = 24;
   localparam int TCW_COUNT = 512;
   localparam int TCW_IDX_W = 9;
   localparam int TCW_W = 16;
   localparam int PAGE_OFS_W = 11;
   localparam int REGION_OFS_W = 15;
   localparam int PAGES_PER_CHAN_W = 6;
   localparam int TCW_BUS_MEM_BIT = 15;
   localparam logic [TCW_W-1:0] TCW_RESET = 16'h0000;
endpackage

// >>> design/sdat_tcw_table.sv
// Translation control word table: 512 words, one write port, one registered read port.
// Assumes writer and reader share ref_clk; read data appears one edge after the index.
`timescale 1ns/100ps
module sdat_tcw_table (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [sdat_pkg::TCW_IDX_W-1:0] wr_index,
   input wire logic [sdat_pkg::TCW_W-1:0] wr_data,
   input wire logic [sdat_pkg::TCW_IDX_W-1:0] rd_index,
   output logic [sdat_pkg::TCW_W-1:0] rd_data
);
   logic [sdat_pkg::TCW_W-1:0] word_mem [sdat_pkg::TCW_COUNT];

   ////////////////////////////////////////////////////////////////////////
   // Storage left unreset so it maps onto RAM; software loads it before use
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         word_mem[wr_index] <= wr_data;
      end
   end

   // Registered read, old data on a same-index write
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rd_data <= sdat_pkg::TCW_RESET;
      end else begin
         rd_data <= word_mem[rd_index];
      end
   end
endmodule

// >>> design/sdat_translate.sv
// Segment translation for processor references and TCW translation for DMA references.
// Assumes requesters and register writers run on ref_clk; no pins cross domains.
//
// Function
// - Top four effective address bits pick a segment; low 28 bits are offset.
// - Sixteen segment registers, 0 to 15, translate processor references.
// - Segments are linear spaces of 2K pages, at most 2^28 bytes.
// - Segment register bits 0 to 14 are reserved and ignored.
// - Bit 15 valid; translation through a register only when set.
// - Channel-inhibit set blocks I/O channel access to the segment.
// - Processor-inhibit set blocks processor access to the segment.
// - Bits 18 to 29 hold the segment identifier; 30, 31 ignored.
// - Segment 15 windows: F0 to bus I/O, F4 to bus memory.
// - Segment 14 translates references from I/O bus masters.
// - Eight DMA channels, addresses translated through translation control words.
// - A word gives high physical bits and system or bus memory choice.
// - Page mode: each word maps a 2K page, 64 per channel.
// - Region mode: each word maps 32K, 512 shared by all channels.
// - Region mode only for alternate controllers; page mode for all.
`timescale 1ns/100ps
module sdat_translate (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic seg_wr_en,
   input wire logic [3:0] seg_index,
   input wire logic [31:0] seg_wdata,
   output logic [31:0] seg_rdata,
   input wire logic tcw_wr_en,
   input wire logic [sdat_pkg::TCW_IDX_W-1:0] tcw_index,
   input wire logic [sdat_pkg::TCW_W-1:0] tcw_wdata,
   input wire logic [sdat_pkg::CHAN_COUNT-1:0] chan_region,
   input wire logic [sdat_pkg::CHAN_COUNT-1:0] chan_alternate,
   input wire logic cpu_req,
   input wire logic [31:0] cpu_ea,
   output logic cpu_done,
   output logic cpu_fault,
   output logic cpu_io_space,
   output logic cpu_bus_mem,
   output logic [sdat_pkg::VADDR_W-1:0] cpu_vaddr,
   input wire logic dma_req,
   input wire logic [sdat_pkg::CHAN_W-1:0] dma_chan,
   input wire logic [sdat_pkg::DMA_ADDR_W-1:0] dma_addr,
   output logic dma_done,
   output logic dma_fault,
   output logic dma_bus_mem,
   output logic [sdat_pkg::VADDR_W-1:0] dma_vaddr
);
   logic [31:0] seg_reg [sdat_pkg::SEG_COUNT];
   logic [3:0] cpu_sel;
   logic [31:0] cpu_seg;
   logic [3:0] cpu_win;
   logic cpu_out_seg;
   logic cpu_bad_win;
   logic [sdat_pkg::TCW_IDX_W-1:0] dma_index;
   logic dma_bad_mode;
   logic s1_req_reg;
   logic s1_region_reg;
   logic s1_bad_reg;
   logic [sdat_pkg::REGION_OFS_W-1:0] s1_ofs_reg;
   logic [sdat_pkg::TCW_W-1:0] tcw_word;
   logic [31:0] seg_in;
   logic [sdat_pkg::DMA_ADDR_W-1:0] dma_phys;

   ////////////////////////////////////////////////////////////////////////
   // Segment registers, one per generate entry
   genvar gi;
   generate
      for (gi = 0; gi < sdat_pkg::SEG_COUNT; gi++) begin : g_seg
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               seg_reg[gi] <= sdat_pkg::SEG_RESET;
            end else if (seg_wr_en && seg_index == 4'(gi)) begin
               seg_reg[gi] <= seg_wdata; // Reserved bits kept for readback only
            end
         end
      end
   endgenerate

   // Readback of the addressed register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         seg_rdata <= 32'h0000_0000;
      end else begin
         seg_rdata <= seg_reg[seg_index];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Processor path: one cycle, decoded from the selected segment
   assign cpu_sel = cpu_ea[sdat_pkg::EA_SEL_MSB:sdat_pkg::EA_SEL_LSB];
   assign cpu_seg = seg_reg[cpu_sel];
   assign cpu_win = cpu_ea[27:24];
   assign cpu_out_seg = cpu_sel == sdat_pkg::SEG_IO_OUT;
   // Only the two bus windows of the outbound segment are decoded
   assign cpu_bad_win = cpu_out_seg && cpu_win != sdat_pkg::WIN_BUS_IO && cpu_win != sdat_pkg::WIN_BUS_MEM;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cpu_done <= 1'b0;
         cpu_fault <= 1'b0;
         cpu_io_space <= 1'b0;
         cpu_bus_mem <= 1'b0;
         cpu_vaddr <= '0;
      end else begin
         cpu_done <= cpu_req;
         cpu_fault <= cpu_req && (!cpu_seg[sdat_pkg::SEG_VALID_BIT]
            || cpu_seg[sdat_pkg::SEG_PROC_INH_BIT] || cpu_bad_win);
         cpu_io_space <= cpu_req && cpu_out_seg && cpu_win == sdat_pkg::WIN_BUS_IO;
         cpu_bus_mem <= cpu_req && cpu_out_seg && cpu_win == sdat_pkg::WIN_BUS_MEM;
         // Identifier and offset only; bits 0-14 and 30-31 never reach the result
         cpu_vaddr <= {cpu_seg[sdat_pkg::SEG_SID_MSB:sdat_pkg::SEG_SID_LSB],
            cpu_ea[sdat_pkg::OFFSET_W-1:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // DMA stage 1: choose the translation word; table read takes one edge
   always_comb begin
      if (chan_region[dma_chan]) begin
         dma_index = dma_addr[sdat_pkg::DMA_ADDR_W-1:sdat_pkg::REGION_OFS_W];
         dma_bad_mode = !chan_alternate[dma_chan];
      end else begin
         dma_index = {dma_chan, dma_addr[16:sdat_pkg::PAGE_OFS_W]};
         // Beyond the channel's 64 pages there is no word to use
         dma_bad_mode = dma_addr[sdat_pkg::DMA_ADDR_W-1:17] != 7'h00;
      end
   end

   sdat_tcw_table u_tcw (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(tcw_wr_en),
      .wr_index(tcw_index),
      .wr_data(tcw_wdata),
      .rd_index(dma_index),
      .rd_data(tcw_word)
   );

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1_req_reg <= 1'b0;
         s1_region_reg <= 1'b0;
         s1_bad_reg <= 1'b0;
         s1_ofs_reg <= '0;
      end else begin
         s1_req_reg <= dma_req;
         s1_region_reg <= chan_region[dma_chan];
         s1_bad_reg <= dma_bad_mode;
         s1_ofs_reg <= dma_addr[sdat_pkg::REGION_OFS_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // DMA stage 2: high bits from the word, then through segment 14
   assign seg_in = seg_reg[sdat_pkg::SEG_IO_IN];
   assign dma_phys = s1_region_reg ? {tcw_word[8:0], s1_ofs_reg}
      : {tcw_word[12:0], s1_ofs_reg[sdat_pkg::PAGE_OFS_W-1:0]};

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dma_done <= 1'b0;
         dma_fault <= 1'b0;
         dma_bus_mem <= 1'b0;
         dma_vaddr <= '0;
      end else begin
         dma_done <= s1_req_reg;
         dma_fault <= s1_req_reg && (s1_bad_reg || !seg_in[sdat_pkg::SEG_VALID_BIT]
            || seg_in[sdat_pkg::SEG_CHAN_INH_BIT]);
         dma_bus_mem <= s1_req_reg && tcw_word[sdat_pkg::TCW_BUS_MEM_BIT];
         dma_vaddr <= {seg_in[sdat_pkg::SEG_SID_MSB:sdat_pkg::SEG_SID_LSB], 4'h0, dma_phys};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence dma_region_s;
      dma_req && chan_region[dma_chan] && !chan_alternate[dma_chan];
   endsequence

   sequence dma_two_s;
      ##1 s1_req_reg ##1 dma_done;
   endsequence

   cpu_offset_pass_a: assert property (cpu_req |=> cpu_done && cpu_vaddr[27:0] == $past(cpu_ea[27:0]))
      else $error("offset not passed through");
   cpu_invalid_seg_a: assert property (cpu_req && !cpu_seg[15] |=> cpu_fault)
      else $error("invalid segment not faulted");
   cpu_proc_inh_a: assert property (cpu_req && cpu_seg[17] |=> cpu_fault)
      else $error("processor inhibit ignored");
   cpu_sid_map_a: assert property (cpu_req && !cpu_seg[15] == 1'b0 |=> cpu_vaddr[39:28] == $past(cpu_seg[29:18]))
      else $error("segment id mismatch");
   cpu_io_win_a: assert property (cpu_req && cpu_ea[31:24] == 8'hf0 && seg_reg[15][15] && !seg_reg[15][17]
      |=> cpu_io_space && !cpu_bus_mem && !cpu_fault)
      else $error("bus I/O window not decoded");
   dma_latency_a: assert property (dma_req |-> dma_two_s)
      else $error("DMA answer not two cycles later");
   dma_region_alt_a: assert property (dma_region_s |-> ##2 dma_fault)
      else $error("region mode allowed for system controller");
   dma_chan_inh_a: assert property (dma_done && !dma_fault |-> !$past(seg_in[16]) && $past(seg_in[15]))
      else $error("DMA passed an inhibited segment");
   dma_page_ofs_a: assert property (dma_req && !chan_region[dma_chan] |-> ##2 dma_vaddr[10:0] == $past(dma_addr[10:0], 2))
      else $error("page offset not preserved");
endmodule

// >>> verification/sdat_dma_master.sv
// DMA master on the I/O channel side: turns a bench go pulse into one dma request.
// Assumes ref_clk and rst_n are shared with the translation block.
`timescale 1ns/100ps
module sdat_dma_master (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic [2:0] go_chan,
   input wire logic [23:0] go_addr,
   output logic dma_req = 1'b0,
   output logic [2:0] dma_chan = 3'h0,
   output logic [23:0] dma_addr = 24'h000000
);
   ////////////////////////////////////////////////////////////////////////
   // One request per go; idle lines toggle so stale values never look valid
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dma_req <= 1'b0;
      end else if (go) begin
         dma_req <= 1'b1;
         dma_chan <= go_chan;
         dma_addr <= go_addr;
      end else begin
         dma_req <= 1'b0;
         dma_chan <= ~dma_chan;
         dma_addr <= ~dma_addr;
      end
   end
endmodule

// >>> verification/segment_and_dma_address_translation_tb_top.sv
// Self-checking bench for segment and DMA translation.
// Assumes the notes' latencies: cpu answer 1 cycle, dma answer 2 cycles.
`timescale 1ns/100ps
module segment_and_dma_address_translation_tb_top;
   logic ref_clk = 1'b0, rst_n = 1'b0, seg_wr_en = 1'b0, tcw_wr_en = 1'b0, cpu_req = 1'b0, go = 1'b0;
   logic [3:0] seg_index = 4'h0;
   logic [31:0] seg_wdata = 32'h0, seg_rdata, cpu_ea = 32'h0;
   logic [8:0] tcw_index = 9'h000;
   logic [15:0] tcw_wdata = 16'h0000;
   logic [7:0] chan_region = 8'h80, chan_alternate = 8'h80;
   logic [2:0] go_chan = 3'h0, dma_chan;
   logic [23:0] go_addr = 24'h0, dma_addr;
   logic cpu_done, cpu_fault, cpu_io_space, cpu_bus_mem, dma_req, dma_done, dma_fault, dma_bus_mem;
   logic [39:0] cpu_vaddr, dma_vaddr;
   int bad_count = 0, checks_done = 0, cycle_count = 0;
   sdat_translate u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .seg_wr_en(seg_wr_en), .seg_index(seg_index),
      .seg_wdata(seg_wdata), .seg_rdata(seg_rdata), .tcw_wr_en(tcw_wr_en), .tcw_index(tcw_index),
      .tcw_wdata(tcw_wdata), .chan_region(chan_region), .chan_alternate(chan_alternate), .cpu_req(cpu_req),
      .cpu_ea(cpu_ea), .cpu_done(cpu_done), .cpu_fault(cpu_fault), .cpu_io_space(cpu_io_space),
      .cpu_bus_mem(cpu_bus_mem), .cpu_vaddr(cpu_vaddr), .dma_req(dma_req), .dma_chan(dma_chan),
      .dma_addr(dma_addr), .dma_done(dma_done), .dma_fault(dma_fault), .dma_bus_mem(dma_bus_mem),
      .dma_vaddr(dma_vaddr));
   sdat_dma_master u_master (.ref_clk(ref_clk), .rst_n(rst_n), .go(go), .go_chan(go_chan), .go_addr(go_addr),
      .dma_req(dma_req), .dma_chan(dma_chan), .dma_addr(dma_addr));
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard, ceiling well above the roughly 130 cycles needed
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycle_count++;
      if (cycle_count == 3000) begin
         bad_count++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [43:0] got, input logic [43:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Segment word with valid set; reserved bits left zero
   function automatic logic [31:0] segw(input logic [11:0] sid, input logic p, input logic i);
      return {2'b00, sid, p, i, 1'b1, 15'h0000};
   endfunction
   task automatic seg_wr(input logic [3:0] idx, input logic [31:0] d);
      @(posedge ref_clk) begin seg_wr_en <= 1'b1; seg_index <= idx; seg_wdata <= d; end
      @(posedge ref_clk) seg_wr_en <= 1'b0;
   endtask
   task automatic tcw_wr(input logic [8:0] idx, input logic [15:0] d);
      @(posedge ref_clk) begin tcw_wr_en <= 1'b1; tcw_index <= idx; tcw_wdata <= d; end
      @(posedge ref_clk) tcw_wr_en <= 1'b0;
   endtask
   // Vaddr and window flags are only judged when no fault is expected
   task automatic cpu_x(input logic [31:0] ea, input logic f, input logic io, input logic bm,
                        input logic [39:0] va);
      @(posedge ref_clk) begin cpu_req <= 1'b1; cpu_ea <= ea; end
      @(posedge ref_clk) begin cpu_req <= 1'b0; cpu_ea <= ~ea; end
      #1;
      check({42'h0, cpu_done, cpu_fault}, {42'h0, 1'b1, f});
      if (!f) check({cpu_io_space, cpu_bus_mem, cpu_vaddr}, {2'b00, io, bm, va});
   endtask
   task automatic dma_x(input logic [2:0] ch, input logic [23:0] a, input logic f, input logic bm,
                        input logic [39:0] va);
      @(posedge ref_clk) begin go <= 1'b1; go_chan <= ch; go_addr <= a; end
      @(posedge ref_clk) go <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check({42'h0, dma_done, dma_fault}, {42'h0, 1'b1, f});
      if (!f) check({dma_bus_mem, dma_vaddr}, {3'b000, bm, va});
   endtask
   task automatic page_x(input logic [2:0] ch, input logic [23:0] a, input logic [15:0] w);
      tcw_wr({ch, a[16:11]}, w);
      dma_x(ch, a, 1'b0, w[15], {12'h5a5, 4'h0, w[12:0], a[10:0]});
   endtask
   task automatic region_x(input logic [2:0] ch, input logic [23:0] a, input logic [15:0] w, input logic f);
      tcw_wr(a[23:15], w);
      dma_x(ch, a, f, w[15], {12'h5a5, 4'h0, w[8:0], a[14:0]});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk) #1 check({12'h0, seg_rdata}, 44'h0);
      cpu_x(32'h0000_0100, 1'b1, 1'b0, 1'b0, 40'h0);
      for (int i = 0; i < 14; i++) begin
         seg_wr(i[3:0], segw({8'h00, i[3:0]}, 1'b0, 1'b0));
         cpu_x({i[3:0], 28'h0000800}, 1'b0, 1'b0, 1'b0, {8'h00, i[3:0], 28'h0000800});
      end
      seg_wr(4'h3, 32'heaf1_ffff);
      @(posedge ref_clk) #1 check({12'h0, seg_rdata}, {12'h0, 32'heaf1_ffff});
      cpu_x(32'h3123_4567, 1'b0, 1'b0, 1'b0, {12'habc, 28'h1234567});
      seg_wr(4'h5, segw(12'h001, 1'b1, 1'b0));
      cpu_x(32'h5000_0000, 1'b1, 1'b0, 1'b0, 40'h0);
      seg_wr(4'hf, segw(12'h0ff, 1'b0, 1'b0));
      cpu_x(32'hf012_3456, 1'b0, 1'b1, 1'b0, {12'h0ff, 28'h0123456});
      cpu_x(32'hf4ff_fffc, 1'b0, 1'b0, 1'b1, {12'h0ff, 28'h4fffffc});
      cpu_x(32'hf100_0000, 1'b1, 1'b0, 1'b0, 40'h0);
      dma_x(3'h2, 24'h01_9abc, 1'b1, 1'b0, 40'h0);
      seg_wr(4'he, segw(12'h5a5, 1'b1, 1'b0));
      page_x(3'h2, 24'h01_9abc, 16'h8123);
      page_x(3'h3, 24'h01_ffff, 16'h1fff);
      dma_x(3'h2, 24'h02_0000, 1'b1, 1'b0, 40'h0);
      region_x(3'h7, 24'h3c_1234, 16'h81a5, 1'b0);
      @(posedge ref_clk) chan_region <= 8'h82;
      region_x(3'h1, 24'h3c_1234, 16'h81a5, 1'b1);
      seg_wr(4'he, segw(12'h5a5, 1'b1, 1'b0));
      page_x(3'h2, 24'h01_9abc, 16'h8123);
      seg_wr(4'he, segw(12'h5a5, 1'b0, 1'b1));
      dma_x(3'h2, 24'h01_9abc, 1'b1, 1'b0, 40'h0);
      test_done();
   end
endmodule
